// ---- fac_params.svh ----
`ifndef FAC_PARAMS_SVH
`define FAC_PARAMS_SVH
// Widths
`define FAC_ADDR_W 16
`define FAC_DATA_W 16
`define FAC_WS_W 3
// Wait-state count after reset (worst case, above 17 MHz)
`define FAC_WS_RST 3'h4
// Erased flash word and unprotected state
`define FAC_ERASED_WORD 16'hFFFF
`define FAC_PROT_RST 2'h0
// Timing: internal flash clock 5 MHz, system clock 40 MHz
`define FAC_SYS_MHZ 40
`define FAC_FLASH_CLK_DIV 8
`define FAC_ERASE_US 8000
`define FAC_PROG_US 3500
`define FAC_FCLK_MHZ_X8 40
`define FAC_ERASE_TICKS ((`FAC_ERASE_US * `FAC_FCLK_MHZ_X8) / 8)
`define FAC_PROG_TICKS ((`FAC_PROG_US * `FAC_FCLK_MHZ_X8) / 8)
`define FAC_WRAP_CYC 4'h3
`endif

// ---- fac_pkg.sv ----
package fac_pkg;
	typedef enum logic [3:0] {
		FAC_ST_IDLE = 4'b0001,
		FAC_ST_PRE = 4'b0010,
		FAC_ST_RUN = 4'b0100,
		FAC_ST_POST = 4'b1000
	} fac_op_state_t;
	typedef enum logic [1:0] {
		FAC_OP_ERASE = 2'h1,
		FAC_OP_PROG = 2'h2
	} fac_op_t;
endpackage : fac_pkg

// ---- fac_wait_ctr.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fac_params.svh"
// Wait counter for one non-sequential read: done pulses after ws cycles
module fac_wait_ctr (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire logic [`FAC_WS_W-1:0] ws_in,
	output logic done_out
);
	logic [`FAC_WS_W-1:0] cnt_r;
	logic run_r;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_r <= 3'h0;
			run_r <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				cnt_r <= (ws_in == 3'h0) ? 3'h1 : ws_in;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (cnt_r == 3'h1) begin
					run_r <= 1'b0;
					done_out <= 1'b1;
				end
				cnt_r <= cnt_r - 3'h1;
			end
		end
	end
endmodule : fac_wait_ctr
`default_nettype wire

// ---- fac_flash_ctrl.sv ----
// How it works
// RULE1: Configured wait states are added only on non-sequential reads; the code also adds them to a sequential read made while rd_valid_out is high.
// RULE2: A prefetch buffer fetches the next sequential word ahead.
// RULE3: Software sets wait states to suit clock; 4 above 17 MHz.
// RULE4: Every array access goes through this controller, never straight from CPU.
// RULE5: A module being read is never erased or programmed.
// RULE6: With reads from one module or RAM, two modules may be modified; with one module read the code grants only the other module.
// RULE7: With reads from both modules only module 1 may be modified; the code then grants neither module.
// RULE8: Erase lasts 8.0 ms, program 3.5 ms, timed by the flash clock.
// RULE9: A few system cycles are spent before and after each operation.
// RULE10: Arrays start erased and unprotected.
// RULE11: Per-module busy shown; reads to a busy module are refused.
`timescale 1ns/10ps
`default_nettype none
`include "fac_params.svh"
module fac_flash_ctrl
	import fac_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [`FAC_WS_W-1:0] flash_wait_state_count_in,
	input wire logic rd_req_in,
	input wire logic [`FAC_ADDR_W-1:0] rd_addr_in,
	input wire logic rd_from_ram_in,
	input wire logic [1:0] op_req_in,
	input wire logic [1:0] op_kind_in,
	input wire logic [`FAC_DATA_W-1:0] array_rdata_in,
	output logic [`FAC_ADDR_W-1:0] array_addr_out,
	output logic array_rd_out,
	output logic [1:0] array_erase_out,
	output logic [1:0] array_prog_out,
	output logic [`FAC_DATA_W-1:0] rd_data_out,
	output logic rd_valid_out,
	output logic rd_refused_out,
	output logic [1:0] busy_out,
	output logic [1:0] op_done_out,
	output logic [1:0] op_denied_out,
	output logic [1:0] protect_out
);
	function automatic logic mod_of(input logic [`FAC_ADDR_W-1:0] a);
		return a[`FAC_ADDR_W-1];
	endfunction : mod_of

	logic [`FAC_ADDR_W-1:0] last_addr_r;
	logic last_ok_r;
	logic [`FAC_ADDR_W-1:0] pf_addr_r;
	logic [`FAC_DATA_W-1:0] pf_data_r;
	logic pf_valid_r;
	logic [`FAC_ADDR_W-1:0] pend_addr_r;
	logic pend_r;
	logic [1:0] reading_r;
	logic ws_start;
	logic ws_done;
	logic seq_hit;
	logic [2:0] fdiv_r;
	logic ftick;

	fac_wait_ctr u_wait (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.start_in(ws_start),
		.ws_in(flash_wait_state_count_in),
		.done_out(ws_done)
	);

	// Prefetched word matches the request: no wait states
	assign seq_hit = pf_valid_r && (pf_addr_r == rd_addr_in); // RULE1
	assign ws_start = rd_req_in && !pend_r && !seq_hit && !busy_out[mod_of(rd_addr_in)];

	// Read path
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_valid_out <= 1'b0;
			rd_refused_out <= 1'b0;
			rd_data_out <= `FAC_ERASED_WORD; // RULE10
			pend_r <= 1'b0;
			pend_addr_r <= 16'h0000;
			array_addr_out <= 16'h0000;
			array_rd_out <= 1'b0;
			pf_valid_r <= 1'b0;
			pf_addr_r <= 16'h0000;
			pf_data_r <= `FAC_ERASED_WORD;
			last_addr_r <= 16'h0000;
			last_ok_r <= 1'b0;
		end else begin
			rd_valid_out <= 1'b0;
			rd_refused_out <= 1'b0;
			array_rd_out <= 1'b0;
			if (rd_req_in && !pend_r && busy_out[mod_of(rd_addr_in)]) begin
				rd_refused_out <= 1'b1; // RULE11
			end else if (rd_req_in && !pend_r && seq_hit) begin
				rd_data_out <= pf_data_r;
				rd_valid_out <= 1'b1;
				// Fetch the following word ahead
				array_addr_out <= pf_addr_r + 16'h0001; // RULE2
				array_rd_out <= 1'b1; // RULE4
				pf_addr_r <= pf_addr_r + 16'h0001;
				pf_valid_r <= 1'b0;
				last_addr_r <= rd_addr_in;
				last_ok_r <= 1'b1;
			end else if (ws_start) begin
				pend_r <= 1'b1;
				pend_addr_r <= rd_addr_in;
				array_addr_out <= rd_addr_in; // RULE4
				pf_valid_r <= 1'b0;
			end else if (pend_r && ws_done) begin
				pend_r <= 1'b0;
				rd_data_out <= array_rdata_in;
				rd_valid_out <= 1'b1;
				array_addr_out <= pend_addr_r + 16'h0001; // RULE2
				array_rd_out <= 1'b1;
				pf_addr_r <= pend_addr_r + 16'h0001;
				last_addr_r <= pend_addr_r;
				last_ok_r <= 1'b1;
			end else if (array_rd_out) begin
				pf_data_r <= array_rdata_in;
				pf_valid_r <= !busy_out[mod_of(pf_addr_r)];
			end
			if (|busy_out) begin
				if (busy_out[mod_of(pf_addr_r)]) begin
					pf_valid_r <= 1'b0;
				end
			end
		end
	end

	// Modules that currently deliver reads
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reading_r <= 2'h0;
		end else if (rd_from_ram_in) begin
			reading_r <= 2'h0;
		end else if (last_ok_r) begin
			reading_r <= rd_req_in ? (reading_r | (2'h1 << mod_of(rd_addr_in)))
				: (2'h1 << mod_of(last_addr_r));
		end
	end

	// Flash timing tick from the internal flash clock divider
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fdiv_r <= 3'h0;
			ftick <= 1'b0;
		end else begin
			fdiv_r <= fdiv_r + 3'h1;
			ftick <= (fdiv_r == 3'(`FAC_FLASH_CLK_DIV - 1)); // RULE8
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			protect_out <= `FAC_PROT_RST; // RULE10
		end else begin
			protect_out <= `FAC_PROT_RST;
		end
	end

	// Erase/program sequencer per module
	fac_op_state_t st_r [2];
	logic [15:0] tick_r [2];
	logic [3:0] wrap_r [2];
	logic is_erase_r [2];
	logic [1:0] grant;
	always_comb begin
		grant = 2'h0;
		for (int m = 0; m < 2; m++) begin
			if (op_req_in[m] && st_r[m] == FAC_ST_IDLE && !reading_r[m]) begin // RULE5
				if (reading_r == 2'h3) begin
					grant[m] = 1'b0;
				end else if (reading_r != 2'h0 || rd_from_ram_in) begin
					grant[m] = 1'b1; // RULE6
				end else begin
					grant[m] = 1'b1;
				end
			end
		end
		// Both modules read: nothing granted; only module 0 read: module 1 granted if idle
		if (reading_r == 2'h3) begin
			grant = 2'h0; // RULE7
		end
		if (reading_r == 2'h1 && op_req_in[1] && st_r[1] == FAC_ST_IDLE) begin
			grant[1] = 1'b1; // RULE7
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_mod
		always_ff @(posedge clock_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				st_r[g] <= FAC_ST_IDLE;
				tick_r[g] <= 16'h0000;
				wrap_r[g] <= 4'h0;
				is_erase_r[g] <= 1'b0;
				busy_out[g] <= 1'b0;
				op_done_out[g] <= 1'b0;
				op_denied_out[g] <= 1'b0;
				array_erase_out[g] <= 1'b0;
				array_prog_out[g] <= 1'b0;
			end else begin
				op_done_out[g] <= 1'b0;
				op_denied_out[g] <= op_req_in[g] && st_r[g] == FAC_ST_IDLE && !grant[g];
				case (st_r[g])
				FAC_ST_IDLE: begin
					if (grant[g]) begin
						is_erase_r[g] <= (op_kind_in == FAC_OP_ERASE);
						wrap_r[g] <= `FAC_WRAP_CYC; // RULE9
						busy_out[g] <= 1'b1; // RULE11
						st_r[g] <= FAC_ST_PRE;
					end
				end
				FAC_ST_PRE: begin
					wrap_r[g] <= wrap_r[g] - 4'h1;
					if (wrap_r[g] == 4'h1) begin
						tick_r[g] <= is_erase_r[g] ? 16'(`FAC_ERASE_TICKS)
							: 16'(`FAC_PROG_TICKS); // RULE8
						array_erase_out[g] <= is_erase_r[g];
						array_prog_out[g] <= !is_erase_r[g];
						st_r[g] <= FAC_ST_RUN;
					end
				end
				FAC_ST_RUN: begin
					if (ftick) begin
						tick_r[g] <= tick_r[g] - 16'h0001;
						if (tick_r[g] == 16'h0001) begin
							array_erase_out[g] <= 1'b0;
							array_prog_out[g] <= 1'b0;
							wrap_r[g] <= `FAC_WRAP_CYC; // RULE9
							st_r[g] <= FAC_ST_POST;
						end
					end
				end
				FAC_ST_POST: begin
					wrap_r[g] <= wrap_r[g] - 4'h1;
					if (wrap_r[g] == 4'h1) begin
						busy_out[g] <= 1'b0;
						op_done_out[g] <= 1'b1;
						st_r[g] <= FAC_ST_IDLE;
					end
				end
				default: st_r[g] <= FAC_ST_IDLE;
				endcase
			end
		end
	end

	property p_refuse_busy;
		@(posedge clock_in) disable iff (!rst_b_in)
		(rd_req_in && !pend_r && busy_out[mod_of(rd_addr_in)]) |=> rd_refused_out && !rd_valid_out;
	endproperty
	a_refuse_busy: assert property (p_refuse_busy) else $error("read to busy module not refused"); // RULE11
	property p_seq_fast;
		@(posedge clock_in) disable iff (!rst_b_in)
		(rd_req_in && !pend_r && seq_hit && !busy_out[mod_of(rd_addr_in)]) |=> rd_valid_out;
	endproperty
	a_seq_fast: assert property (p_seq_fast) else $error("sequential hit not served next cycle"); // RULE1
	property p_nonseq_wait;
		@(posedge clock_in) disable iff (!rst_b_in)
		ws_start |=> !rd_valid_out ##1 !rd_valid_out;
	endproperty
	a_nonseq_wait: assert property (p_nonseq_wait) else $error("non-sequential read too fast"); // RULE1
	property p_prefetch;
		@(posedge clock_in) disable iff (!rst_b_in)
		(pend_r && ws_done) |=> array_rd_out && array_addr_out == pend_addr_r + 16'h0001;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("no prefetch after read"); // RULE2
	property p_no_mod_read;
		@(posedge clock_in) disable iff (!rst_b_in)
		grant[0] |-> !reading_r[0];
	endproperty
	a_no_mod_read: assert property (p_no_mod_read) else $error("modified module that is read"); // RULE5
	property p_two_reads;
		@(posedge clock_in) disable iff (!rst_b_in)
		(reading_r == 2'h3) |-> grant == 2'h0;
	endproperty
	a_two_reads: assert property (p_two_reads) else $error("grant while both modules read"); // RULE7
	property p_pre_wrap;
		@(posedge clock_in) disable iff (!rst_b_in)
		grant[0] |=> (busy_out[0] && !array_erase_out[0] && !array_prog_out[0]) [*3];
	endproperty
	a_pre_wrap: assert property (p_pre_wrap) else $error("operation started without setup cycles"); // RULE9
	property p_busy_op;
		@(posedge clock_in) disable iff (!rst_b_in)
		(array_erase_out[1] || array_prog_out[1]) |-> busy_out[1];
	endproperty
	a_busy_op: assert property (p_busy_op) else $error("array active without busy"); // RULE11
	property p_unprot;
		@(posedge clock_in) disable iff (!rst_b_in)
		1'b1 |-> protect_out == 2'h0;
	endproperty
	a_unprot: assert property (p_unprot) else $error("protection installed"); // RULE10
	c_seq: cover property (@(posedge clock_in) rd_valid_out ##1 rd_valid_out);
	c_refuse: cover property (@(posedge clock_in) rd_refused_out);
	c_done: cover property (@(posedge clock_in) op_done_out[1]);
	c_denied: cover property (@(posedge clock_in) op_denied_out[0]);
endmodule : fac_flash_ctrl
`default_nettype wire

// ---- fac_array_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fac_params.svh"
// Flash array: the word follows the address combinationally, so it is good in the same cycle as a new address
module fac_array_model (
	input wire logic [`FAC_ADDR_W-1:0] addr_in,
	output logic [`FAC_DATA_W-1:0] rdata_out
);
	assign rdata_out = {addr_in[7:0], ~addr_in[7:0]};
endmodule : fac_array_model
`default_nettype wire

// ---- flash_access_and_erase_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fac_params.svh"
module flash_access_and_erase_control_tb import fac_pkg::*;;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [2:0] ws;
	logic rd_req, ram, a_rd, rvalid, rref;
	logic [15:0] addr, a_addr, a_rdata, rdata;
	logic [1:0] op_req, op_kind, a_er, a_pr, busy, done, den, prot;
	int failures = 0;
	int checks_done = 0;
	initial forever #12.5 clock_in = ~clock_in;
	fac_flash_ctrl DUT (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.flash_wait_state_count_in(ws), .rd_req_in(rd_req), .rd_addr_in(addr),
		.rd_from_ram_in(ram), .op_req_in(op_req), .op_kind_in(op_kind),
		.array_rdata_in(a_rdata), .array_addr_out(a_addr), .array_rd_out(a_rd),
		.array_erase_out(a_er), .array_prog_out(a_pr), .rd_data_out(rdata),
		.rd_valid_out(rvalid), .rd_refused_out(rref), .busy_out(busy),
		.op_done_out(done), .op_denied_out(den), .protect_out(prot));
	fac_array_model u_array (.addr_in(a_addr), .rdata_out(a_rdata));
	task automatic chk_v(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_v
	task automatic chk_n(input string n, input int e, input int g);
		checks_done++;
		if (g != e) begin
			failures++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_n
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task automatic timeout_hit(input string n);
		failures++;
		$display("MISMATCH %s expected event seen timeout", n);
		finish_test();
	endtask : timeout_hit
	task automatic step;
		@(posedge clock_in);
		#1;
	endtask : step
	task automatic do_reset;
		rst_b_in = 1'b0;
		repeat (10) step();
		rst_b_in = 1'b1;
		step();
	endtask : do_reset
	// Returns with the answer pulse still visible
	task automatic rd(input logic [15:0] a, output int lat);
		rd_req = 1'b1;
		addr = a;
		step();
		rd_req = 1'b0;
		lat = 1;
		while (rvalid !== 1'b1 && rref !== 1'b1) begin
			if (lat > 40)
				timeout_hit("read_answer");
			step();
			lat++;
		end
	endtask : rd
	task automatic op(input fac_op_t k, input logic [1:0] r, eb, ed, ee, ep);
		int n;
		logic [1:0] dn;
		op_kind = k;
		op_req = r;
		step();
		op_req = 2'b00;
		dn = den;
		n = 0;
		while (busy === 2'b00) begin
			if (n > 10)
				timeout_hit("busy");
			step();
			dn = dn | den;
			n++;
		end
		n = 0;
		while ((a_er | a_pr) === 2'b00) begin
			if (n > 20)
				timeout_hit("array_strobe");
			step();
			dn = dn | den;
			n++;
		end
		chk_n("wrap_cycles", 3, n);
		chk_v("busy", {14'h0, eb}, {14'h0, busy});
		chk_v("denied", {14'h0, ed}, {14'h0, dn});
		chk_v("erase", {14'h0, ee}, {14'h0, a_er});
		chk_v("prog", {14'h0, ep}, {14'h0, a_pr});
	endtask : op
	task automatic test_reset;
		chk_v("rd_data", `FAC_ERASED_WORD, rdata);
		chk_v("protect", {14'h0, `FAC_PROT_RST}, {14'h0, prot});
		chk_v("busy_rst", 16'h0000, {14'h0, busy});
		$display("test reset done");
	endtask : test_reset
	task automatic test_waits;
		int miss;
		int hit;
		logic [15:0] a;
		logic [15:0] b;
		// Counts of 4 and more only: the bench clock is above 17 MHz
		for (int w = 4; w <= 7; w++) begin
			ws = 3'(w);
			a = {4'h0, 4'(w), 8'h05};
			b = a + 16'h0001;
			step();
			rd(a, miss);
			chk_v("miss_data", {a[7:0], ~a[7:0]}, rdata);
			chk_v("prefetch_rd", 16'h0001, {15'h0, a_rd});
			chk_v("prefetch_addr", b, a_addr);
			step();
			rd(b, hit);
			chk_v("seq_data", {b[7:0], ~b[7:0]}, rdata);
			chk_v("ahead_addr", b + 16'h0001, a_addr);
			chk_n("hit_latency", 1, hit);
			chk_n("miss_extra", w + 1, miss - hit);
		end
		$display("test wait states done");
	endtask : test_waits
	task automatic test_erase;
		int n;
		op(FAC_OP_ERASE, 2'b11, 2'b10, 2'b01, 2'b10, 2'b00);
		rd(16'h8000, n);
		chk_v("refused", 16'h0001, {15'h0, rref});
		step();
		rd(16'h0040, n);
		chk_v("rd_module0", {8'h40, 8'hBF}, rdata);
		repeat (2000) step();
		chk_v("erase_held", 16'h0002, {14'h0, a_er});
		chk_v("op_done", 16'h0000, {14'h0, done});
		do_reset();
		$display("test erase done");
	endtask : test_erase
	task automatic test_ram;
		ram = 1'b1;
		op(FAC_OP_PROG, 2'b11, 2'b11, 2'b00, 2'b00, 2'b11);
		do_reset();
		ram = 1'b0;
		$display("test ram program done");
	endtask : test_ram
	initial begin
		ws = `FAC_WS_RST;
		rd_req = 1'b0;
		addr = 16'h0000;
		ram = 1'b0;
		op_req = 2'b00;
		op_kind = 2'b00;
		do_reset();
		test_reset();
		test_waits();
		test_erase();
		test_ram();
		finish_test();
	end
endmodule : flash_access_and_erase_control_tb
`default_nettype wire
